// ---- gic_dev.sv ----
// module: device end of the two-wire command port
`timescale 1ns/1ps
`default_nettype none
module gic_dev #(
	parameter int LOC_NUM  = gic_pkg::GIC_LOC_NUM,
	parameter int UNIT_CYC = gic_pkg::GIC_TOUT_UNIT_CYC
) (
	// clock and reset
	input  wire logic        mclk_i,
	input  wire logic        rstn_i,
	// two-wire bus
	gic_bus_if.dev           bus,
	// configuration and firmware update of locations
	input  wire logic [15:0] tout_limit_i,
	input  wire logic        fw_we_i,
	input  wire logic [6:0]  fw_addr_i,
	input  wire logic [7:0]  fw_data_i,
	// host write notification and status
	output logic             hw_we_o,
	output logic      [6:0]  hw_addr_o,
	output logic      [7:0]  hw_data_o,
	output logic             busy_o,
	output logic             tout_o
);
	import gic_pkg::*;

	typedef enum logic [4:0] {
		D_IDLE  = 5'b00001,
		D_ADDR  = 5'b00010,
		D_CMD   = 5'b00100,
		D_WDATA = 5'b01000,
		D_RDATA = 5'b10000
	} gic_dstate_t;

	// read value of a location; beyond the readable range reads zero
	function automatic logic [7:0] rd_loc(input logic [7:0] p, input logic [7:0] m [LOC_NUM]);
		rd_loc = (p > GIC_RD_MAX) ? 8'h00 : m[p[6:0]];
	endfunction

	// ****************************************************************
	// input synchronisers
	// ****************************************************************
	logic [1:0] scl_sync_reg;
	logic [1:0] sda_sync_reg;
	logic       scl_prev_reg;
	logic       sda_prev_reg;

	// first stage is read only by the second stage
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			scl_sync_reg <= 2'h3;
			sda_sync_reg <= 2'h3;
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
		end else begin
			scl_sync_reg <= {scl_sync_reg[0], bus.scl};
			sda_sync_reg <= {sda_sync_reg[0], bus.sda};
			scl_prev_reg <= scl_sync_reg[1];
			sda_prev_reg <= sda_sync_reg[1];
		end
	end

	logic scl_s;
	logic sda_s;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	assign scl_s     = scl_sync_reg[1];
	assign sda_s     = sda_sync_reg[1];
	assign scl_rise  = scl_s && !scl_prev_reg;
	assign scl_fall  = !scl_s && scl_prev_reg;
	assign start_det = scl_s && scl_prev_reg && !sda_s && sda_prev_reg;
	assign stop_det  = scl_s && scl_prev_reg && sda_s && !sda_prev_reg;

	// ****************************************************************
	// protocol engine
	// ****************************************************************
	gic_dstate_t st_reg, st_next;
	logic [3:0]  cnt_reg, cnt_next;
	logic        in_ack_reg, in_ack_next;
	logic [7:0]  sh_reg, sh_next;
	logic [7:0]  ptr_reg, ptr_next;
	logic [1:0]  wcnt_reg, wcnt_next;
	logic        sda_oe_reg, sda_oe_next;
	logic [7:0]  mem_reg [LOC_NUM];
	logic [7:0]  mem_next [LOC_NUM];
	logic        hw_we_next;
	logic [6:0]  hw_addr_next;
	logic [7:0]  hw_data_next;
	logic [15:0] unit_cnt_reg, unit_cnt_next;
	logic [15:0] low_reg, low_next;
	logic        tout_next;
	logic [7:0]  cur_byte;

	// byte at the pointer, sent first after a read address
	assign cur_byte = rd_loc(ptr_reg, mem_reg);

	// next-state of the engine, pointer, store and timeout
	always_comb begin
		st_next       = st_reg;
		cnt_next      = cnt_reg;
		in_ack_next   = in_ack_reg;
		sh_next       = sh_reg;
		ptr_next      = ptr_reg;
		wcnt_next     = wcnt_reg;
		sda_oe_next   = sda_oe_reg;
		mem_next      = mem_reg;
		hw_we_next    = 1'b0;
		hw_addr_next  = hw_addr_o;
		hw_data_next  = hw_data_o;
		unit_cnt_next = unit_cnt_reg;
		low_next      = low_reg;
		tout_next     = 1'b0;
		if (fw_we_i) begin
			mem_next[fw_addr_i] = fw_data_i;
		end
		if (start_det) begin
			st_next     = D_ADDR;
			cnt_next    = 4'h0;
			in_ack_next = 1'b0;
			sda_oe_next = 1'b0;
		end else if (stop_det) begin
			st_next     = D_IDLE;
			in_ack_next = 1'b0;
			sda_oe_next = 1'b0;
		end else if (scl_rise) begin
			if (st_reg == D_RDATA) begin
				// only the host's ack slot counts; our own address ack must not move the pointer
				if (in_ack_reg && !sda_oe_reg) begin
					if (!sda_s) begin
						ptr_next = ptr_reg + 8'h01;
						sh_next  = rd_loc(ptr_reg + 8'h01, mem_reg);
					end else begin
						st_next     = D_IDLE;
						in_ack_next = 1'b0;
					end
				end
			end else if (st_reg != D_IDLE && !in_ack_reg && cnt_reg < 4'h8) begin
				sh_next  = {sh_reg[6:0], sda_s};
				cnt_next = cnt_reg + 4'h1;
			end
		end else if (scl_fall) begin
			case (st_reg)
				D_ADDR: begin
					if (cnt_reg == 4'h8 && !in_ack_reg) begin
						if (sh_reg[7:1] != GIC_TGT_ADDR) begin
							st_next = D_IDLE;
						end else begin
							in_ack_next = 1'b1;
							sda_oe_next = 1'b1;
							if (sh_reg[0]) begin
								st_next = D_RDATA;
							end else begin
								st_next = D_CMD;
							end
						end
					end
				end
				D_CMD, D_WDATA: begin
					if (in_ack_reg) begin
						in_ack_next = 1'b0;
						sda_oe_next = 1'b0;
						cnt_next    = 4'h0;
					end else if (cnt_reg == 4'h8) begin
						if (st_reg == D_CMD) begin
							if (sh_reg > GIC_RD_MAX) begin
								st_next = D_IDLE;
							end else begin
								ptr_next    = sh_reg;
								wcnt_next   = 2'h0;
								st_next     = D_WDATA;
								in_ack_next = 1'b1;
								sda_oe_next = 1'b1;
							end
						end else begin
							in_ack_next = 1'b1;
							if (ptr_reg < GIC_RO_BASE && wcnt_reg < 2'(GIC_WR_MAX_BYTES)) begin
								sda_oe_next                = 1'b1;
								mem_next[ptr_reg[6:0]]     = sh_reg;
								ptr_next                   = ptr_reg + 8'h01;
								wcnt_next                  = wcnt_reg + 2'h1;
								hw_we_next                 = 1'b1;
								hw_addr_next               = ptr_reg[6:0];
								hw_data_next               = sh_reg;
							end // nack leaves location untouched
						end
					end
				end
				D_RDATA: begin
					if (in_ack_reg && sda_oe_reg) begin
						// end of address ack: first byte at the pointer
						in_ack_next = 1'b0;
						sda_oe_next = !cur_byte[7];
						sh_next     = {cur_byte[6:0], 1'b1};
						cnt_next    = 4'h1;
					end else if (in_ack_reg) begin
						in_ack_next = 1'b0;
						sda_oe_next = !sh_reg[7];
						sh_next     = {sh_reg[6:0], 1'b1};
						cnt_next    = 4'h1;
					end else if (cnt_reg < 4'h8) begin
						sda_oe_next = !sh_reg[7];
						sh_next     = {sh_reg[6:0], 1'b1};
						cnt_next    = cnt_reg + 4'h1;
					end else begin
						sda_oe_next = 1'b0;
						in_ack_next = 1'b1;
					end
				end
				default: begin
					sda_oe_next = 1'b0;
				end
			endcase
		end
		// stuck-low watchdog counted in whole units
		if (scl_s && sda_s) begin
			low_next      = 16'h0000;
			unit_cnt_next = 16'h0000;
		end else if (unit_cnt_reg == 16'(UNIT_CYC - 1)) begin
			unit_cnt_next = 16'h0000;
			if (low_reg != 16'hffff) begin
				low_next = low_reg + 16'h0001;
			end
			if (tout_limit_i != 16'h0000 && low_reg + 16'h0001 == tout_limit_i) begin
				tout_next   = 1'b1;
				st_next     = D_IDLE;
				in_ack_next = 1'b0;
				sda_oe_next = 1'b0;
			end
		end else begin
			unit_cnt_next = unit_cnt_reg + 16'h0001;
		end
	end

	// register the engine; locations reset to zero
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_reg       <= D_IDLE;
			cnt_reg      <= 4'h0;
			in_ack_reg   <= 1'b0;
			sh_reg       <= 8'h00;
			ptr_reg      <= 8'h00;
			wcnt_reg     <= 2'h0;
			sda_oe_reg   <= 1'b0;
			mem_reg      <= '{default: 8'h00};
			hw_we_o      <= 1'b0;
			hw_addr_o    <= 7'h00;
			hw_data_o    <= 8'h00;
			busy_o       <= 1'b0;
			tout_o       <= 1'b0;
			unit_cnt_reg <= 16'h0000;
			low_reg      <= 16'h0000;
		end else begin
			st_reg       <= st_next;
			cnt_reg      <= cnt_next;
			in_ack_reg   <= in_ack_next;
			sh_reg       <= sh_next;
			ptr_reg      <= ptr_next;
			wcnt_reg     <= wcnt_next;
			sda_oe_reg   <= sda_oe_next;
			mem_reg      <= mem_next;
			hw_we_o      <= hw_we_next;
			hw_addr_o    <= hw_addr_next;
			hw_data_o    <= hw_data_next;
			busy_o       <= (st_next != D_IDLE);
			tout_o       <= tout_next;
			unit_cnt_reg <= unit_cnt_next;
			low_reg      <= low_next;
		end
	end

	// device only ever pulls sda; no clock stretching, so scl stays released
	assign bus.sda_d_o  = 1'b0;
	assign bus.sda_d_oe = sda_oe_reg;
	assign bus.scl_d_o  = 1'b0;
	assign bus.scl_d_oe = 1'b0;

endmodule
`default_nettype wire

// ---- gic_pkg.sv ----
// package: shared constants and types for the two-wire command port
package gic_pkg;

	// ****************************************************************
	// addressing
	// ****************************************************************
	localparam logic [6:0] GIC_TGT_ADDR     = 7'h55;
	localparam logic [7:0] GIC_ADDR_WR      = 8'haa;
	localparam logic [7:0] GIC_ADDR_RD      = 8'hab;
	localparam logic [7:0] GIC_RD_MAX       = 8'h7f;
	localparam logic [7:0] GIC_RO_BASE      = 8'h40;
	localparam int         GIC_WR_MAX_BYTES = 2;
	localparam int         GIC_LOC_NUM      = 128;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int GIC_CLK_MHZ      = 250;
	localparam int GIC_SCL_MAX_KHZ  = 400;
	localparam int GIC_SCL_QTR_CYC  = (GIC_CLK_MHZ * 1000 + 4 * GIC_SCL_MAX_KHZ - 1)
		/ (4 * GIC_SCL_MAX_KHZ);
	localparam int GIC_TOUT_UNIT_US  = 1;
	localparam int GIC_TOUT_UNIT_CYC = GIC_TOUT_UNIT_US * GIC_CLK_MHZ;

	// ****************************************************************
	// host byte operations
	// ****************************************************************
	typedef enum logic [2:0] {
		GIC_OP_START_W = 3'h0,
		GIC_OP_START_R = 3'h1,
		GIC_OP_WRITE   = 3'h2,
		GIC_OP_READ    = 3'h3,
		GIC_OP_STOP    = 3'h4
	} gic_op_t;

endpackage

// ---- gic_bus_if.sv ----
// interface: open-drain two-wire bus joining host and device ends
`timescale 1ns/1ps
`default_nettype none
interface gic_bus_if;
	logic scl_h_o;
	logic scl_h_oe;
	logic sda_h_o;
	logic sda_h_oe;
	logic scl_d_o;
	logic scl_d_oe;
	logic sda_d_o;
	logic sda_d_oe;
	logic scl;
	logic sda;

	// wired-and: any enabled low driver pulls the line, else pulled up
	assign scl = !((scl_h_oe && !scl_h_o) || (scl_d_oe && !scl_d_o));
	assign sda = !((sda_h_oe && !sda_h_o) || (sda_d_oe && !sda_d_o));

	modport host (output scl_h_o, scl_h_oe, sda_h_o, sda_h_oe, input scl, sda);
	modport dev  (output scl_d_o, scl_d_oe, sda_d_o, sda_d_oe, input scl, sda);
endinterface
`default_nettype wire

// ---- gic_host.sv ----
// module: host end, byte-level controller of the two-wire bus
`timescale 1ns/1ps
`default_nettype none
module gic_host #(
	parameter int QTR_CYC = gic_pkg::GIC_SCL_QTR_CYC
) (
	// clock and reset
	input  wire logic            mclk_i,
	input  wire logic            rstn_i,
	// two-wire bus
	gic_bus_if.host              bus,
	// operation request
	input  wire logic            op_valid_i,
	input  wire gic_pkg::gic_op_t op_i,
	input  wire logic [7:0]      op_data_i,
	input  wire logic            op_ack_i,
	output logic                 op_ready_o,
	// operation result
	output logic                 done_o,
	output logic      [7:0]      rdata_o,
	output logic                 nack_o
);
	import gic_pkg::*;

	typedef enum logic [3:0] {
		H_IDLE  = 4'b0001,
		H_START = 4'b0010,
		H_BIT   = 4'b0100,
		H_STOP  = 4'b1000
	} gic_hstate_t;

	// ****************************************************************
	// input synchroniser
	// ****************************************************************
	logic [1:0] sda_sync_reg;

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sda_sync_reg <= 2'h3;
		end else begin
			sda_sync_reg <= {sda_sync_reg[0], bus.sda};
		end
	end

	// ****************************************************************
	// quarter-bit sequencer
	// ****************************************************************
	gic_hstate_t st_reg, st_next;
	logic [15:0] div_reg, div_next;
	logic [1:0]  ph_reg, ph_next;
	logic [3:0]  bit_reg, bit_next;
	logic [8:0]  sh_reg, sh_next;
	logic        scl_oe_reg, scl_oe_next;
	logic        sda_oe_reg, sda_oe_next;
	logic        done_next;
	logic [7:0]  rdata_next;
	logic        nack_next;
	logic        qtick;

	// quarter period rounded up keeps scl at or below the ceiling
	assign qtick = (div_reg == 16'(QTR_CYC - 1));

	// next-state of the sequencer; one bit every four quarter ticks
	always_comb begin
		st_next     = st_reg;
		div_next    = qtick ? 16'h0000 : div_reg + 16'h0001;
		ph_next     = ph_reg;
		bit_next    = bit_reg;
		sh_next     = sh_reg;
		scl_oe_next = scl_oe_reg;
		sda_oe_next = sda_oe_reg;
		done_next   = 1'b0;
		rdata_next  = rdata_o;
		nack_next   = nack_o;
		case (st_reg)
			H_IDLE: begin
				div_next = 16'h0000;
				ph_next  = 2'h0;
				if (op_valid_i) begin
					bit_next = 4'h0;
					case (op_i)
						// target comes with the request; direction bit is forced by the op
						GIC_OP_START_W: begin
							st_next = H_START;
							sh_next = {op_data_i[7:1], 1'b0, 1'b1};
						end
						GIC_OP_START_R: begin
							st_next = H_START;
							sh_next = {op_data_i[7:1], 1'b1, 1'b1};
						end
						GIC_OP_WRITE: begin
							st_next = H_BIT;
							sh_next = {op_data_i, 1'b1};
						end
						GIC_OP_READ: begin
							st_next = H_BIT;
							sh_next = {8'hff, !op_ack_i};
						end
						default: begin
							st_next = H_STOP;
						end
					endcase
				end
			end
			H_START: begin
				if (qtick) begin
					ph_next = ph_reg + 2'h1;
					case (ph_reg)
						2'h0: sda_oe_next = 1'b0;
						2'h1: scl_oe_next = 1'b0;
						2'h2: sda_oe_next = 1'b1;
						default: begin
							scl_oe_next = 1'b1;
							st_next     = H_BIT;
						end
					endcase
				end
			end
			H_BIT: begin
				if (qtick) begin
					ph_next = ph_reg + 2'h1;
					case (ph_reg)
						2'h0: sda_oe_next = !sh_reg[8];
						2'h1: scl_oe_next = 1'b0;
						2'h2: sh_next = {sh_reg[7:0], sda_sync_reg[1]};
						default: begin
							scl_oe_next = 1'b1;
							bit_next    = bit_reg + 4'h1;
							if (bit_reg == 4'h8) begin
								// hold scl low and release sda between bytes
								sda_oe_next = 1'b0;
								st_next     = H_IDLE;
								done_next   = 1'b1;
								rdata_next  = sh_reg[8:1];
								nack_next   = sh_reg[0];
							end
						end
					endcase
				end
			end
			H_STOP: begin
				if (qtick) begin
					ph_next = ph_reg + 2'h1;
					case (ph_reg)
						2'h0: sda_oe_next = 1'b1;
						2'h1: scl_oe_next = 1'b0;
						2'h2: sda_oe_next = 1'b0;
						default: begin
							st_next   = H_IDLE;
							done_next = 1'b1;
							nack_next = 1'b0;
						end
					endcase
				end
			end
			default: begin
				st_next = H_IDLE;
			end
		endcase
	end

	// register the sequencer
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_reg     <= H_IDLE;
			div_reg    <= 16'h0000;
			ph_reg     <= 2'h0;
			bit_reg    <= 4'h0;
			sh_reg     <= 9'h000;
			scl_oe_reg <= 1'b0;
			sda_oe_reg <= 1'b0;
			op_ready_o <= 1'b0;
			done_o     <= 1'b0;
			rdata_o    <= 8'h00;
			nack_o     <= 1'b0;
		end else begin
			st_reg     <= st_next;
			div_reg    <= div_next;
			ph_reg     <= ph_next;
			bit_reg    <= bit_next;
			sh_reg     <= sh_next;
			scl_oe_reg <= scl_oe_next;
			sda_oe_reg <= sda_oe_next;
			op_ready_o <= (st_next == H_IDLE) && !(st_reg == H_IDLE && op_valid_i);
			done_o     <= done_next;
			rdata_o    <= rdata_next;
			nack_o     <= nack_next;
		end
	end

	// open-drain: only ever pull low
	assign bus.scl_h_o  = 1'b0;
	assign bus.scl_h_oe = scl_oe_reg;
	assign bus.sda_h_o  = 1'b0;
	assign bus.sda_h_oe = sda_oe_reg;

endmodule
`default_nettype wire

// ---- gic_props.sv ----
// checker: concurrent properties on the two-wire bus and device status
`timescale 1ns/1ps
`default_nettype none
module gic_props (
	// clock and reset
	input wire logic        mclk_i,
	input wire logic        rstn_i,
	// resolved bus and device drivers
	input wire logic        scl,
	input wire logic        sda,
	input wire logic        scl_d_oe,
	input wire logic        sda_d_oe,
	// device status
	input wire logic        hw_we_o,
	input wire logic        busy_o,
	input wire logic        tout_o,
	input wire logic [15:0] tout_limit_i
);
	// ****************************************************************
	// clocking and shared sequences
	// ****************************************************************
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rstn_i);

	// start condition: data falls while the clock stays high
	sequence s_start;
		scl && $past(scl) && $fell(sda);
	endsequence

	// a stored byte comes while the clock is low inside a live transfer
	sequence s_store;
		hw_we_o && busy_o && !scl;
	endsequence

	// ****************************************************************
	// assertions
	// ****************************************************************
	AST_NO_CLK_DRIVE: assert property (!scl_d_oe)
		else $error("device pulled the clock line");
	AST_TOUT_RELEASE: assert property (tout_o |=> (!sda_d_oe && !scl_d_oe) [*4])
		else $error("device kept a line after timeout");
	AST_TOUT_OFF: assert property (tout_limit_i == 16'h0000 |-> !tout_o)
		else $error("timeout fired while disabled");
	AST_TOUT_LOW: assert property (tout_o |-> $past(!scl || !sda))
		else $error("timeout fired on an idle bus");
	AST_SDA_CHG: assert property ($changed(sda_d_oe) |-> !scl)
		else $error("device moved data while clock high");
	AST_START_FREE: assert property (s_start |-> !sda_d_oe)
		else $error("device pulled data at a start");
	AST_STORE_CTX: assert property (hw_we_o |-> s_store)
		else $error("store outside a live transfer");
	AST_STORE_PULSE: assert property (hw_we_o |=> !hw_we_o)
		else $error("store pulse longer than one cycle");
	AST_TOUT_PULSE: assert property (tout_o |=> !tout_o)
		else $error("timeout pulse longer than one cycle");
endmodule
`default_nettype wire

// ---- gauge_i2c_command_port_tb_top.sv ----
// testbench: host end drives transfers into the device end
`timescale 1ns/1ps
`default_nettype none
module gauge_i2c_command_port_tb_top;
	import gic_pkg::*;
	// ****************************************************************
	// signals
	// ****************************************************************
	logic        mclk_i;
	logic        rstn_i;
	logic [15:0] tout_limit_i;
	logic        fw_we_i;
	logic [6:0]  fw_addr_i;
	logic [7:0]  fw_data_i;
	logic        hw_we_o;
	logic [6:0]  hw_addr_o;
	logic [7:0]  hw_data_o;
	logic        busy_o;
	logic        tout_o;
	logic        op_valid_i;
	gic_op_t     op_i;
	logic [7:0]  op_data_i;
	logic        op_ack_i;
	logic        op_ready_o;
	logic        done_o;
	logic [7:0]  rdata_o;
	logic        nack_o;
	int          err_count;
	int          comparisons;
	int          we_count;
	logic        scl_q;
	logic        sda_q;
	logic [7:0]  shift;
	int          nbits;
	logic [7:0]  addr_seen;

	// ****************************************************************
	// instances
	// ****************************************************************
	gic_bus_if gic_bus_if_inst ();
	gic_dev #(.LOC_NUM(128), .UNIT_CYC(4)) gic_dev_inst (
		.mclk_i(mclk_i), .rstn_i(rstn_i), .bus(gic_bus_if_inst),
		.tout_limit_i(tout_limit_i), .fw_we_i(fw_we_i), .fw_addr_i(fw_addr_i),
		.fw_data_i(fw_data_i), .hw_we_o(hw_we_o), .hw_addr_o(hw_addr_o),
		.hw_data_o(hw_data_o), .busy_o(busy_o), .tout_o(tout_o));
	gic_host #(.QTR_CYC(8)) gic_host_inst (
		.mclk_i(mclk_i), .rstn_i(rstn_i), .bus(gic_bus_if_inst),
		.op_valid_i(op_valid_i), .op_i(op_i), .op_data_i(op_data_i), .op_ack_i(op_ack_i),
		.op_ready_o(op_ready_o), .done_o(done_o), .rdata_o(rdata_o), .nack_o(nack_o));
	gic_props gic_props_inst (
		.mclk_i(mclk_i), .rstn_i(rstn_i), .scl(gic_bus_if_inst.scl),
		.sda(gic_bus_if_inst.sda), .scl_d_oe(gic_bus_if_inst.scl_d_oe),
		.sda_d_oe(gic_bus_if_inst.sda_d_oe), .hw_we_o(hw_we_o), .busy_o(busy_o),
		.tout_o(tout_o), .tout_limit_i(tout_limit_i));

	// ****************************************************************
	// clock, store counter and wire monitor
	// ****************************************************************
	always #2 mclk_i = ~mclk_i;

	// first byte after each start, sampled on clock rise
	always @(posedge mclk_i) begin
		scl_q <= gic_bus_if_inst.scl;
		sda_q <= gic_bus_if_inst.sda;
		if (hw_we_o === 1'b1)
			we_count++;
		if (scl_q && gic_bus_if_inst.scl && sda_q && !gic_bus_if_inst.sda)
			nbits <= 0;
		else if (!scl_q && gic_bus_if_inst.scl) begin
			shift <= {shift[6:0], gic_bus_if_inst.sda};
			nbits <= nbits + 1;
			if (nbits == 7)
				addr_seen <= {shift[6:0], gic_bus_if_inst.sda};
		end
	end

	// ****************************************************************
	// tasks
	// ****************************************************************
	task automatic final_report();
		if (err_count == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// hold the request until taken, then wait for completion, bounded
	task automatic run_op(input gic_op_t o, input logic [7:0] d, input logic a);
		int n;
		@(posedge mclk_i);
		op_valid_i <= 1'b1;
		op_i <= o;
		op_data_i <= d;
		op_ack_i <= a;
		n = 0;
		do begin @(posedge mclk_i); n++; end while (op_ready_o !== 1'b1 && n < 100);
		op_valid_i <= 1'b0;
		if (n >= 100) begin
			err_count++;
			$display("ERROR at %0t: operation never taken", $time);
		end
		n = 0;
		do begin @(posedge mclk_i); n++; end while (done_o !== 1'b1 && n < 2000);
		if (n >= 2000) begin
			err_count++;
			$display("ERROR at %0t: operation never completed", $time);
		end
	endtask

	task automatic xfer(input gic_op_t o, input logic [7:0] d, input logic exp_nack);
		run_op(o, d, 1'b0);
		chk({7'h00, nack_o}, {7'h00, exp_nack});
	endtask

	task automatic rd(input logic a, input logic [7:0] exp);
		run_op(GIC_OP_READ, 8'h00, a);
		chk(rdata_o, exp);
	endtask

	// select a location, then read two bytes with a repeated start
	task automatic rd_at(input logic [7:0] cmd, input logic [7:0] e0, input logic [7:0] e1);
		xfer(GIC_OP_START_W, GIC_ADDR_WR, 1'b0);
		xfer(GIC_OP_WRITE, cmd, 1'b0);
		xfer(GIC_OP_START_R, GIC_ADDR_RD, 1'b0);
		chk(addr_seen, 8'hab);
		rd(1'b1, e0);
		rd(1'b0, e1);
		run_op(GIC_OP_STOP, 8'h00, 1'b0);
	endtask

	task automatic fw_load(input logic [6:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		fw_we_i <= 1'b1;
		fw_addr_i <= a;
		fw_data_i <= d;
		@(posedge mclk_i);
		fw_we_i <= 1'b0;
	endtask

	// ****************************************************************
	// watchdog
	// ****************************************************************
	initial begin
		repeat (60000) @(posedge mclk_i);
		err_count++;
		$display("ERROR at %0t: watchdog expired", $time);
		final_report();
	end

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		int n;
		mclk_i = 1'b0;
		rstn_i <= 1'b0;
		tout_limit_i <= 16'h0000;
		fw_we_i <= 1'b0;
		fw_addr_i <= 7'h00;
		fw_data_i <= 8'h00;
		op_valid_i <= 1'b0;
		op_i <= GIC_OP_STOP;
		op_data_i <= 8'h00;
		op_ack_i <= 1'b0;
		err_count = 0;
		comparisons = 0;
		we_count = 0;
		repeat (8) @(posedge mclk_i);
		rstn_i <= 1'b1;
		repeat (2) @(posedge mclk_i);
		// two-byte write, third byte refused
		xfer(GIC_OP_START_W, GIC_ADDR_WR, 1'b0);
		chk(addr_seen, 8'haa);
		xfer(GIC_OP_WRITE, 8'h10, 1'b0);
		xfer(GIC_OP_WRITE, 8'ha5, 1'b0);
		xfer(GIC_OP_WRITE, 8'h5a, 1'b0);
		xfer(GIC_OP_WRITE, 8'h77, 1'b1);
		run_op(GIC_OP_STOP, 8'h00, 1'b0);
		chk(we_count[7:0], 8'h02);
		chk({1'b0, hw_addr_o}, 8'h11);
		chk(hw_data_o, 8'h5a);
		// incremental read back, then quick read at the pointer
		rd_at(8'h10, 8'ha5, 8'h5a);
		xfer(GIC_OP_START_R, GIC_ADDR_RD, 1'b0);
		rd(1'b0, 8'h5a);
		run_op(GIC_OP_STOP, 8'h00, 1'b0);
		// read-only location keeps its value
		fw_load(7'h45, 8'h3c);
		xfer(GIC_OP_START_W, GIC_ADDR_WR, 1'b0);
		xfer(GIC_OP_WRITE, 8'h45, 1'b0);
		xfer(GIC_OP_WRITE, 8'h99, 1'b1);
		run_op(GIC_OP_STOP, 8'h00, 1'b0);
		chk(we_count[7:0], 8'h02);
		rd_at(8'h45, 8'h3c, 8'h00);
		// top readable location, then one past it
		fw_load(7'h7f, 8'hc3);
		rd_at(8'h7f, 8'hc3, 8'h00);
		xfer(GIC_OP_START_W, GIC_ADDR_WR, 1'b0);
		xfer(GIC_OP_WRITE, 8'h80, 1'b1);
		run_op(GIC_OP_STOP, 8'h00, 1'b0);
		// foreign address is ignored
		xfer(GIC_OP_START_W, 8'h90, 1'b1);
		xfer(GIC_OP_WRITE, 8'h10, 1'b1);
		run_op(GIC_OP_STOP, 8'h00, 1'b0);
		// host parks clock low mid-read while the device holds data low, until it gives up
		tout_limit_i <= 16'h0064;
		xfer(GIC_OP_START_W, GIC_ADDR_WR, 1'b0);
		xfer(GIC_OP_WRITE, 8'h10, 1'b0);
		xfer(GIC_OP_START_R, GIC_ADDR_RD, 1'b0);
		rd(1'b1, 8'ha5);
		repeat (4) @(posedge mclk_i);
		chk({7'h00, gic_bus_if_inst.sda_d_oe}, 8'h01);
		n = 0;
		do begin @(posedge mclk_i); n++; end while (tout_o !== 1'b1 && n < 1000);
		chk({7'h00, tout_o}, 8'h01);
		@(posedge mclk_i);
		chk({7'h00, gic_bus_if_inst.sda_d_oe}, 8'h00);
		chk({7'h00, gic_bus_if_inst.sda}, 8'h01);
		run_op(GIC_OP_STOP, 8'h00, 1'b0);
		tout_limit_i <= 16'h0000;
		rd_at(8'h10, 8'ha5, 8'h5a);
		final_report();
	end
endmodule
`default_nettype wire
